// File: include/eampm_pkg.sv
// eampm_pkg: register map, field positions and reset values for the address pin mux
// assumes an axi4-lite slave with 32-bit data and word-aligned registers
package eampm_pkg;
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  OFF_BUS_SELECT  = 8'h00;
  localparam logic [7:0]  OFF_PULL_DIS    = 8'h04;
  localparam logic [7:0]  OFF_MEM_CTRL    = 8'h08;
  localparam logic [7:0]  OFF_GIO_OUT     = 8'h0C;
  localparam logic [7:0]  OFF_GIO_DIR     = 8'h10;
  localparam logic [7:0]  OFF_GIO_IN      = 8'h14;
  localparam logic [7:0]  OFF_PIN_STATUS  = 8'h18;
  localparam int unsigned SHARED_N        = 6;
  localparam int unsigned SHARED_LO       = 15;
  localparam int unsigned GIO_LO          = 21;
  localparam int unsigned CLE_BIT         = 12;
  localparam int unsigned ALE_BIT         = 11;
  localparam int unsigned MC_WIDE_POS     = 0;
  localparam int unsigned MC_NAND_POS     = 1;
  localparam logic [5:0]  BUS_SELECT_RST  = 6'h00;
  localparam logic [5:0]  PULL_DIS_RST    = 6'h00;
  localparam logic [1:0]  MEM_CTRL_RST    = 2'h0;
  localparam logic [5:0]  GIO_RST         = 6'h00;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// File: rtl/eampm_pin_sync.sv
// eampm_pin_sync: three-stage synchroniser for the shared pin inputs
// assumes pins are asynchronous to aclk; a change counts when stages two and three agree
`timescale 1ns/1ps
module eampm_pin_sync (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [5:0] pin_async,
  output logic      [5:0] pin_sync
);
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic [5:0] s3_reg;
  logic [5:0] held_reg;
  wire  [5:0] agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg   <= 6'h00;
      s2_reg   <= 6'h00;
      s3_reg   <= 6'h00;
      held_reg <= 6'h00;
    end else begin
      s1_reg   <= pin_async;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      held_reg <= (held_reg & ~agree) | (s3_reg & agree);
    end
  end

  assign pin_sync = held_reg;
endmodule

// File: rtl/eampm_addr_pin_mux.sv
// eampm_addr_pin_mux: upper address and bank pin routing, gpio sharing and nand latch enables
// assumes the memory controller presents a byte address, an access strobe and nand phase flags
// Notes on behaviour
// - 8-bit memory: pins carry address 22..2, bank 1..0
// - 16-bit memory: pins carry 21..1, upper bank bit 0
// - address pins 20..15 shared with io lines 26..21
// - per-pin select bit chooses address or io
// - nand: address pin 12 is command latch
// - nand: address pin 11 is address latch
// - pull-down per shared pin disabled by register
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module eampm_addr_pin_mux (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [22:0] mem_addr,
  input  wire logic        mem_drive,
  input  wire logic        nand_cmd_phase,
  input  wire logic        nand_addr_phase,
  output logic [20:0]      ext_addr_bus_o,
  output logic [20:0]      ext_addr_bus_oe,
  input  wire logic [5:0]  shared_pin_i,
  output logic [1:0]       ext_bank_addr_o,
  output logic [1:0]       ext_bank_addr_oe,
  output logic [5:0]       internal_pulldown_en
);
  // registers
  logic [5:0]  bus_select_reg;
  logic [5:0]  pull_disable_reg_two;
  logic [1:0]  mem_ctrl_reg;
  logic [5:0]  gio_out_reg;
  logic [5:0]  gio_dir_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [20:0] addr_o_reg;
  logic [20:0] addr_oe_reg;
  logic [1:0]  bank_o_reg;
  logic [1:0]  bank_oe_reg;
  logic [5:0]  pd_en_reg;
  logic [5:0]  pin_in;

  eampm_pin_sync u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_async (shared_pin_i),
    .pin_sync  (pin_in)
  );

  // write path: address and data taken in either order, response after both
  wire        aw_take    = s_axi_awvalid & ~aw_held_reg & ~bvalid_reg;
  wire        w_take     = s_axi_wvalid & ~w_held_reg & ~bvalid_reg;
  wire        wr_go      = aw_held_reg & w_held_reg;
  wire [7:0]  wr_off     = aw_addr_reg;
  wire        wr_sel_bs  = wr_off == eampm_pkg::OFF_BUS_SELECT;
  wire        wr_sel_pd  = wr_off == eampm_pkg::OFF_PULL_DIS;
  wire        wr_sel_mc  = wr_off == eampm_pkg::OFF_MEM_CTRL;
  wire        wr_sel_go  = wr_off == eampm_pkg::OFF_GIO_OUT;
  wire        wr_sel_gd  = wr_off == eampm_pkg::OFF_GIO_DIR;
  wire        wr_sel_ro  = (wr_off == eampm_pkg::OFF_GIO_IN) | (wr_off == eampm_pkg::OFF_PIN_STATUS);
  wire        wr_mapped  = wr_sel_bs | wr_sel_pd | wr_sel_mc | wr_sel_go | wr_sel_gd | wr_sel_ro;
  wire        wr_lane0   = wr_go & w_strb_reg[0];
  wire [5:0]  wr_byte6   = w_data_reg[5:0];

  // read path
  wire        rd_take    = s_axi_arvalid & ~rvalid_reg;
  wire [7:0]  rd_off     = s_axi_araddr;
  // status: [21:16] shared pin oe, [13:12] bank oe, [9:8] mem ctrl, [5:0] pull-down enables
  wire [31:0] status_w   = {10'h000, addr_oe_reg[20:15], 2'h0, bank_oe_reg, 2'h0, mem_ctrl_reg, 2'h0, pd_en_reg};
  wire        rd_hit     = (rd_off == eampm_pkg::OFF_BUS_SELECT) | (rd_off == eampm_pkg::OFF_PULL_DIS) |
                           (rd_off == eampm_pkg::OFF_MEM_CTRL) | (rd_off == eampm_pkg::OFF_GIO_OUT) |
                           (rd_off == eampm_pkg::OFF_GIO_DIR) | (rd_off == eampm_pkg::OFF_GIO_IN) |
                           (rd_off == eampm_pkg::OFF_PIN_STATUS);
  wire [31:0] rd_val     = (rd_off == eampm_pkg::OFF_BUS_SELECT) ? {26'h0, bus_select_reg} :
                           (rd_off == eampm_pkg::OFF_PULL_DIS)   ? {26'h0, pull_disable_reg_two} :
                           (rd_off == eampm_pkg::OFF_MEM_CTRL)   ? {30'h0, mem_ctrl_reg} :
                           (rd_off == eampm_pkg::OFF_GIO_OUT)    ? {26'h0, gio_out_reg} :
                           (rd_off == eampm_pkg::OFF_GIO_DIR)    ? {26'h0, gio_dir_reg} :
                           (rd_off == eampm_pkg::OFF_GIO_IN)     ? {26'h0, pin_in} :
                           (rd_off == eampm_pkg::OFF_PIN_STATUS) ? status_w : 32'h0000_0000;

  // address routing
  wire        wide_mem   = mem_ctrl_reg[eampm_pkg::MC_WIDE_POS];
  wire        nand_mode  = mem_ctrl_reg[eampm_pkg::MC_NAND_POS];
  wire [20:0] mem_word   = wide_mem ? mem_addr[21:1] : mem_addr[22:2];
  wire [1:0]  mem_bank   = wide_mem ? {mem_addr[0], 1'b0} : mem_addr[1:0];
  wire [1:0]  bank_oe_w  = wide_mem ? {mem_drive, 1'b0} : {2{mem_drive}};
  wire        cle_w      = nand_mode ? nand_cmd_phase : mem_word[eampm_pkg::CLE_BIT];
  wire        ale_w      = nand_mode ? nand_addr_phase : mem_word[eampm_pkg::ALE_BIT];
  wire [20:0] addr_mux_w;
  wire [20:0] addr_oe_w;

  genvar gi;
  generate
    for (gi = 0; gi < 21; gi++) begin : g_pin
      if (gi >= eampm_pkg::SHARED_LO && gi < eampm_pkg::SHARED_LO + eampm_pkg::SHARED_N) begin : g_shared
        localparam int unsigned K = gi - eampm_pkg::SHARED_LO;
        // select bit set: io line (26..21) owns the pin and memory is cut off
        assign addr_mux_w[gi] = bus_select_reg[K] ? gio_out_reg[K] : mem_word[gi];
        assign addr_oe_w[gi]  = bus_select_reg[K] ? gio_dir_reg[K] : mem_drive;
      end else if (gi == eampm_pkg::CLE_BIT) begin : g_cle
        assign addr_mux_w[gi] = cle_w;
        assign addr_oe_w[gi]  = mem_drive | nand_mode;
      end else if (gi == eampm_pkg::ALE_BIT) begin : g_ale
        assign addr_mux_w[gi] = ale_w;
        assign addr_oe_w[gi]  = mem_drive | nand_mode;
      end else begin : g_plain
        assign addr_mux_w[gi] = mem_word[gi];
        assign addr_oe_w[gi]  = mem_drive;
      end
    end
  endgenerate

  // pull-down stays off while the pin is driven to save current
  wire [5:0]  pd_w = ~pull_disable_reg_two & ~addr_oe_w[20:15];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= eampm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? eampm_pkg::RESP_OKAY : eampm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_select_reg       <= eampm_pkg::BUS_SELECT_RST;
      pull_disable_reg_two <= eampm_pkg::PULL_DIS_RST;
      mem_ctrl_reg         <= eampm_pkg::MEM_CTRL_RST;
      gio_out_reg          <= eampm_pkg::GIO_RST;
      gio_dir_reg          <= eampm_pkg::GIO_RST;
    end else if (wr_lane0) begin
      if (wr_sel_bs) bus_select_reg <= wr_byte6;
      if (wr_sel_pd) pull_disable_reg_two <= wr_byte6;
      if (wr_sel_mc) mem_ctrl_reg <= wr_byte6[1:0];
      if (wr_sel_go) gio_out_reg <= wr_byte6;
      if (wr_sel_gd) gio_dir_reg <= wr_byte6;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= eampm_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= rd_hit ? eampm_pkg::RESP_OKAY : eampm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // pins registered so every pin output leaves a flip-flop; costs one cycle of address latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_o_reg  <= 21'h000000;
      addr_oe_reg <= 21'h000000;
      bank_o_reg  <= 2'h0;
      bank_oe_reg <= 2'h0;
      pd_en_reg   <= 6'h3F;
    end else begin
      addr_o_reg  <= addr_mux_w;
      addr_oe_reg <= addr_oe_w;
      bank_o_reg  <= mem_bank;
      bank_oe_reg <= bank_oe_w;
      pd_en_reg   <= pd_w;
    end
  end

  assign s_axi_awready        = aw_take;
  assign s_axi_wready         = w_take;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = rd_take;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign ext_addr_bus_o       = addr_o_reg;
  assign ext_addr_bus_oe      = addr_oe_reg;
  assign ext_bank_addr_o      = bank_o_reg;
  assign ext_bank_addr_oe     = bank_oe_reg;
  assign internal_pulldown_en = pd_en_reg;
endmodule

// File: bench/eampm_mem_model.sv
// eampm_mem_model: external memory and board on the address pins
// assumes the board may drive io-selected shared pins through ben/bval
`timescale 1ns/1ps
module eampm_mem_model (
  input  wire logic        aclk,
  input  wire logic        wide,
  input  wire logic [20:0] ao,
  input  wire logic [20:0] aoe,
  input  wire logic [1:0]  bo,
  input  wire logic [5:0]  pd,
  input  wire logic [5:0]  ben,
  input  wire logic [5:0]  bval,
  output logic      [5:0]  pin,
  output logic      [22:0] seen
);
  logic [5:0] last_reg;
  initial last_reg = 6'h00;
  // a floating pin shows the inverse of its last level so stale values never match
  assign pin = (aoe[20:15] & ao[20:15]) | (~aoe[20:15] & ben & bval)
             | (~aoe[20:15] & ~ben & ~pd & ~last_reg);
  always @(posedge aclk) last_reg <= pin;
  assign seen = wide ? {1'b0, ao, bo[1]} : {ao, bo};
endmodule

// File: bench/eampm_sva.sv
// eampm_sva: port checks of the address pin mux
// assumes mem_drive low through reset
`timescale 1ns/1ps
module eampm_sva (
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0]  s_axi_bresp, ext_bank_addr_o, ext_bank_addr_oe,
  input wire logic [22:0] mem_addr,
  input wire logic        mem_drive, nand_cmd_phase, nand_addr_phase,
  input wire logic [20:0] ext_addr_bus_o, ext_addr_bus_oe,
  input wire logic [5:0]  internal_pulldown_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_map_byte: assert property ($past(mem_drive) && ext_bank_addr_oe == 2'h3 |->
    ext_bank_addr_o == $past(mem_addr[1:0]) && ext_addr_bus_o[10:0] == $past(mem_addr[12:2])) else $error("byte map");
  chk_map_half: assert property ($past(mem_drive) && ext_bank_addr_oe == 2'h2 |->
    ext_bank_addr_o[1] == $past(mem_addr[0]) && ext_addr_bus_o[10:0] == $past(mem_addr[11:1])) else $error("half map");
  chk_cmd_latch: assert property (ext_addr_bus_oe[12] && !$past(mem_drive) |->
    ext_addr_bus_o[12] == $past(nand_cmd_phase)) else $error("cmd latch");
  chk_addr_latch: assert property (ext_addr_bus_oe[11] && !$past(mem_drive) |->
    ext_addr_bus_o[11] == $past(nand_addr_phase)) else $error("addr latch");
  chk_pull_off: assert property ((ext_addr_bus_oe[20:15] & internal_pulldown_en) == 6'h00)
    else $error("pull on driven pin");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
endmodule
bind eampm_addr_pin_mux eampm_sva i_eampm_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bresp(s_axi_bresp),
  .ext_bank_addr_o(ext_bank_addr_o), .ext_bank_addr_oe(ext_bank_addr_oe), .mem_addr(mem_addr),
  .mem_drive(mem_drive), .nand_cmd_phase(nand_cmd_phase), .nand_addr_phase(nand_addr_phase),
  .ext_addr_bus_o(ext_addr_bus_o), .ext_addr_bus_oe(ext_addr_bus_oe), .internal_pulldown_en(internal_pulldown_en));

// File: bench/ext_mem_addr_pin_mux_tb.sv
// ext_mem_addr_pin_mux_tb: mapping, io sharing, pull and nand checks
// assumes 20 MHz aclk and the memory model on the pins
`timescale 1ns/1ps
module ext_mem_addr_pin_mux_tb;
  typedef struct packed {logic w; logic [22:0] a; logic [1:0] boe;} eampm_row_t;
  eampm_row_t rows [4] = '{'{1'b0, 23'h7FFFFD, 2'h3}, '{1'b0, 23'h2AAAAA, 2'h3},
                           '{1'b1, 23'h355555, 2'h2}, '{1'b1, 23'h00000E, 2'h2}};
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wr_r, bv, arr, rv, md = 1'b0, ncmd = 1'b0, nadr = 1'b0, wide = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] bresp, rresp, bo, boe, r;
  logic [22:0] ma = 23'h0, seen;
  logic [20:0] ao, aoe;
  logic [5:0] pd, spin, ben = 6'h00, bval = 6'h00;
  int bad_count = 0, tests_run = 0;
  always #25 aclk = ~aclk;
  eampm_addr_pin_mux i_eampm_addr_pin_mux (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .mem_addr(ma), .mem_drive(md), .nand_cmd_phase(ncmd), .nand_addr_phase(nadr),
    .ext_addr_bus_o(ao), .ext_addr_bus_oe(aoe), .shared_pin_i(spin), .ext_bank_addr_o(bo),
    .ext_bank_addr_oe(boe), .internal_pulldown_en(pd));
  eampm_mem_model i_eampm_mem_model (.aclk(aclk), .wide(wide), .ao(ao), .aoe(aoe), .bo(bo), .pd(pd),
    .ben(ben), .bval(bval), .pin(spin), .seen(seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) begin r = bresp; bre <= 1'b0; n = 99; end
    end
    if (n < 99) bad_count++;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (rv) begin d = rdat; r = rresp; rre <= 1'b0; n = 99; end
    end
    if (n < 99) bad_count++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk(pd, 32'h3F);
    chk(aoe, 32'h0);
    rd(eampm_pkg::OFF_BUS_SELECT); chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(eampm_pkg::OFF_MEM_CTRL, {31'h0, rows[i].w});
      wide <= rows[i].w; ma <= rows[i].a; md <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(ao, rows[i].w ? rows[i].a[21:1] : rows[i].a[22:2]);
      chk(boe, rows[i].boe);
      chk(aoe, 32'h1FFFFF);
      chk(seen, rows[i].a);
    end
    wr(eampm_pkg::OFF_MEM_CTRL, 32'h0);
    wr(eampm_pkg::OFF_BUS_SELECT, 32'h21);
    wr(eampm_pkg::OFF_GIO_DIR, 32'h01);
    wr(eampm_pkg::OFF_GIO_OUT, 32'h01);
    ma <= 23'h0; ben <= 6'h20; bval <= 6'h20;
    repeat (8) @(posedge aclk);
    chk(aoe[20:15], 32'h1F);
    chk(ao[15], 32'h1);
    chk(pd, 32'h20);
    rd(eampm_pkg::OFF_GIO_IN); chk(d & 32'h21, 32'h21);
    bval <= 6'h00;
    repeat (8) @(posedge aclk);
    rd(eampm_pkg::OFF_GIO_IN); chk(d & 32'h21, 32'h01);
    md <= 1'b0;
    wr(eampm_pkg::OFF_BUS_SELECT, 32'h0);
    wr(eampm_pkg::OFF_PULL_DIS, 32'h0F);
    repeat (2) @(posedge aclk);
    chk(pd, 32'h30);
    chk(aoe, 32'h0);
    rd(eampm_pkg::OFF_PIN_STATUS); chk(d, 32'h0000_0030);
    wr(eampm_pkg::OFF_MEM_CTRL, 32'h2);
    for (int k = 0; k < 2; k++) begin
      ncmd <= k[0]; nadr <= ~k[0];
      repeat (2) @(posedge aclk);
      chk({ao[12:11], aoe[12:11]}, {k[0], ~k[0], 2'h3});
    end
    wr(8'h40, 32'hFF); chk(r, eampm_pkg::RESP_SLVERR);
    rd(8'h40); chk(r, eampm_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    rd(eampm_pkg::OFF_PULL_DIS); chk(d, 32'h0F);
    report_and_stop();
  end
endmodule
